// ### src/slow_clock_source_select.sv
module slow_clock_source_select
  #(
    parameter int HALF_PERIOD = slow_clock_pkg::HALF_PERIOD_CYCLES
  )
  (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // standby rail power-on reset, active low, synchronous
    input wire logic standby_por_n,
    // register port
    input wire slow_clock_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // external slow clock pin
    input wire logic slow_clock_input_pin,
    // selected slow clock and status
    output logic slow_clk_out,
    output logic ext_slow_clock_absent,
    output logic using_internal
  );

  // pin synchroniser; first stage only feeds the second
  logic pin_meta;
  logic pin_sync;
  // presence register, standby domain
  logic [7:0] presence;
  // internal divider
  logic [slow_clock_pkg::HALF_CNT_W-1:0] div_cnt;
  logic int_clk;
  // select state
  slow_clock_pkg::src_state_t state;
  slow_clock_pkg::src_state_t next_state;
  logic next_out;
  logic [7:0] next_rdata;

  // divider width, declared before the decode that casts to it
  localparam int HALF_CNT_W = slow_clock_pkg::HALF_CNT_W;

  // decode
  wire hit = reg_req.addr == slow_clock_pkg::SLOW_CLOCK_PRESENCE_ADDR;
  wire wr_hit = reg_req.wr && hit;
  wire absent = presence[slow_clock_pkg::ABSENT_BIT];
  // the switch follows the registered flag, so the selected source never
  // changes before or in the same cycle as the status output
  wire sel_absent = ext_slow_clock_absent;
  wire div_wrap = div_cnt == HALF_CNT_W'(HALF_PERIOD - 1);

  // read data mux; unmapped addresses read zero
  assign next_rdata = (reg_req.rd && hit) ? presence : slow_clock_pkg::UNMAPPED_READ;

  // two-flop synchroniser for the asynchronous pin
  always_ff @(posedge sys_clk)
  begin
    pin_meta <= slow_clock_input_pin;
    pin_sync <= pin_meta;
  end

  // presence register: only the standby rail reset clears it,
  // so a main reset does not lose the board strap setting
  always_ff @(posedge sys_clk)
  begin
    if (!standby_por_n)
      presence <= slow_clock_pkg::PRESENCE_RESET;
    else if (wr_hit)
      presence <= reg_req.wdata;
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

  // internal slow clock from the system clock; the rate is only nominal
  // since the count rounds down, which is fine for blink and wake timing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_cnt <= '0;
      int_clk <= 1'b0;
    end
    else if (div_wrap)
    begin
      div_cnt <= '0;
      int_clk <= ~int_clk;
    end
    else
      div_cnt <= div_cnt + HALF_CNT_W'(1);
  end

  // glitch-free switch: leave a source only while it is low, hold
  // output low until the new source is also low, then follow it
  always_comb
  begin
    next_state = state;
    next_out = 1'b0;
    unique case (state)
      slow_clock_pkg::SRC_EXT:
      begin
        next_out = pin_sync;
        if (sel_absent && !pin_sync)
          next_state = slow_clock_pkg::SRC_WAIT_OFF;
      end
      slow_clock_pkg::SRC_WAIT_OFF:
      begin
        // wait for a low phase of the internal clock; a flag that drops
        // meanwhile turns back towards the external pin, output still low
        if (!sel_absent)
          next_state = slow_clock_pkg::SRC_WAIT_OFF_INT;
        else if (!int_clk)
          next_state = slow_clock_pkg::SRC_INT;
      end
      slow_clock_pkg::SRC_INT:
      begin
        next_out = int_clk;
        if (!sel_absent && !int_clk)
          next_state = slow_clock_pkg::SRC_WAIT_OFF_INT;
      end
      slow_clock_pkg::SRC_WAIT_OFF_INT:
      begin
        // wait for a low phase of the external clock; a flag that rises
        // meanwhile turns back towards the internal source
        if (sel_absent)
          next_state = slow_clock_pkg::SRC_WAIT_OFF;
        else if (!pin_sync)
          next_state = slow_clock_pkg::SRC_EXT;
      end
      default:
        next_state = slow_clock_pkg::SRC_EXT;
    endcase
  end

  // select state and registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= slow_clock_pkg::SRC_EXT;
      slow_clk_out <= 1'b0;
      ext_slow_clock_absent <= 1'b0;
      using_internal <= 1'b0;
    end
    else
    begin
      state <= next_state;
      slow_clk_out <= next_out;
      ext_slow_clock_absent <= absent;
      using_internal <= next_state == slow_clock_pkg::SRC_INT;
    end
  end

endmodule

// ### include/slow_clock_pkg.sv
// Notes on behaviour
// - external 32.768 kHz clock times slow functions
// - absent flag is bit 0 at 0xF0
// - register cleared only by standby power-on reset
// - 0 means external clock present, default
// - present: external clock drives slow logic
// - absent: derive 32 kHz from 14 MHz (the code divides a 20 MHz system clock)
// - slow functions still work while main powered
package slow_clock_pkg;

  // register map
  localparam logic [7:0] SLOW_CLOCK_PRESENCE_ADDR = 8'hF0;
  localparam int ABSENT_BIT = 0;
  localparam logic [7:0] PRESENCE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // timing: system clock and target slow rate
  localparam int SYS_CLK_HZ = 20000000;
  localparam int INT_SLOW_HZ = 32768;
  // half period of the derived clock in system cycles, rounded down
  localparam int HALF_PERIOD_CYCLES = SYS_CLK_HZ / (2 * INT_SLOW_HZ);
  localparam int HALF_CNT_W = 10;

  // source select states, one-hot
  typedef enum logic [3:0] {
    SRC_EXT = 4'h1,
    SRC_WAIT_OFF = 4'h2,
    SRC_INT = 4'h4,
    SRC_WAIT_OFF_INT = 4'h8
  } src_state_t;

  // register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ### dv/ext_slow_clock_model.sv
// far-side trickle clock; held low while unplugged
module ext_slow_clock_model #(parameter int HP = 1000)
(
  // plug state and pin
  input wire logic absent,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // runs free while present, grounded when absent
  initial
  begin
    pin = 1'b0;
    forever #HP pin = !pin && !absent;
  end
endmodule

// ### dv/slow_clock_source_select_properties.sv
module slow_clock_source_select_properties
(
  // watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic standby_por_n,
  input wire slow_clock_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic slow_clock_input_pin,
  input wire logic slow_clk_out,
  input wire logic ext_slow_clock_absent,
  input wire logic using_internal
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire hit = reg_req.addr == slow_clock_pkg::SLOW_CLOCK_PRESENCE_ADDR;
  // lone write to the register
  sequence wr_f0;
    reg_req.wr && hit && standby_por_n ##1 !reg_req.wr && standby_por_n;
  endsequence
  a_rd_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
    else $error("rdata idle");
  a_rd_unmap: assert property (reg_req.rd && !hit |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_wr_flag: assert property (wr_f0 |=> ext_slow_clock_absent == $past(reg_req.wdata[0], 2))
    else $error("flag");
  a_por_clear: assert property (!standby_por_n && !reg_req.wr |=> ##1 !ext_slow_clock_absent)
    else $error("por");
  a_stay_ext: assert property (!ext_slow_clock_absent[*3] ##0 !using_internal |=> !using_internal)
    else $error("left ext");
  a_stay_int: assert property (ext_slow_clock_absent && using_internal |=> using_internal)
    else $error("left int");
  a_ext_follow: assert property ($rose(slow_clk_out) && !using_internal |->
    $past(slow_clock_input_pin, 2) || $past(slow_clock_input_pin, 3))
    else $error("ext follow");
  a_no_runt: assert property ($rose(slow_clk_out) |-> slow_clk_out[*4])
    else $error("runt");
  a_int_rate: assert property ($rose(slow_clk_out) && using_internal |-> ##4 !slow_clk_out)
    else $error("int rate");
endmodule
bind slow_clock_source_select slow_clock_source_select_properties chk_u (.*);

// ### dv/slow_clock_source_select_tb_top.sv
module slow_clock_source_select_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, standby_por_n = 0, gone = 0;
  slow_clock_pkg::reg_req_t req = '0;
  logic [7:0] rdata, a, b, lfsr = 8'h2F, want = 8'h00;
  logic pin, out, absent, use_int, prev;
  int n_mismatch = 0, n_checks = 0, n_rise = 0;
  localparam int HP_SIM = 4;
  initial forever #25 sys_clk = !sys_clk;
  ext_slow_clock_model m_u (.absent(gone), .pin(pin));
  slow_clock_source_select #(.HALF_PERIOD(HP_SIM)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .standby_por_n(standby_por_n), .reg_req(req), .reg_rdata(rdata),
    .slow_clock_input_pin(pin), .slow_clk_out(out), .ext_slow_clock_absent(absent),
    .using_internal(use_int));
  function logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %h %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one strobe cycle, taken at the next edge
  task acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
    req <= '{ad, d, w, !w};
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] ad, input logic [7:0] exp);
    acc(0, ad, 8'h00);
    req <= '0;
    #1 chk(rdata, exp);
    @(posedge sys_clk);
  endtask
  // bounded wait for the source switch
  task wt(input logic v);
    for (int i = 0; i < 300 && use_int !== v; i++) @(posedge sys_clk);
    chk({7'h00, use_int}, {7'h00, v});
    if (use_int !== v) summarize;
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    standby_por_n <= 1;
    @(posedge sys_clk);
    rd(8'hF0, 8'h00);
    repeat (24)
    begin
      lfsr = nx(lfsr);
      a = lfsr[1] ? 8'hF0 : lfsr;
      b = lfsr[2] ? 8'hF0 : lfsr ^ 8'h0F;
      if (a == 8'hF0) want = lfsr;
      acc(1, a, lfsr);
      rd(b, b == 8'hF0 ? want : 8'h00);
    end
    $display("random done");
    gone <= 1;
    acc(1, 8'hF0, 8'h01);
    req <= '0;
    wt(1);
    repeat (40) @(posedge sys_clk);
    chk({7'h00, absent}, 8'h01);
    // the internal source must run at its set rate on the output
    prev = out;
    repeat (20 * HP_SIM)
    begin
      @(posedge sys_clk);
      n_rise += (out && !prev) ? 1 : 0;
      prev = out;
    end
    chk(8'(n_rise), 8'h0A);
    gone <= 0;
    acc(1, 8'hF0, 8'h00);
    req <= '0;
    wt(0);
    $display("switch done");
    acc(1, 8'hF0, 8'h01);
    req <= '0;
    rst_n <= 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    rd(8'hF0, 8'h01);
    standby_por_n <= 0;
    @(posedge sys_clk);
    standby_por_n <= 1;
    rd(8'hF0, 8'h00);
    $display("reset done");
    summarize;
  end
endmodule
